// ===== core/rffe_frontend.sv
`timescale 1ns/100ps
`include "rffe_map.svh"

// Behaviour
// - transmitting: tx enable high, rx low
// - receiving: tx enable low, rx high
// - path select only when front-end bit set
// - all configuration and AES through serial port
// - 128-bit AES usable in every PHY mode
// - 40kbps BPSK and optional 250kbps O-QPSK
module rffe_frontend #(
    parameter int LEAD_STEP_NS = `RFFE_LEAD_STEP_NS
) (
    input  wire logic                     ref_clk,
    input  wire logic                     nrst,
    input  wire logic                     spi_sclk,
    input  wire logic                     spi_cs_n,
    input  wire logic                     spi_mosi,
    output      logic                     spi_miso,
    input  wire logic                     tx_request,
    input  wire logic                     tx_done,
    input  wire logic                     rx_active,
    output      logic                     phy_tx_go,
    output      logic                     sym_rate_tick,
    output      rffe_pkg::rffe_path_pins_type path_pins,
    output      rffe_pkg::rffe_aes_req_type   aes_req,
    input  wire rffe_pkg::rffe_aes_rsp_type   aes_rsp
);
    import rffe_pkg::*;

    localparam int LEAD_STEP_CYC = (LEAD_STEP_NS * (`RFFE_CLK_HZ / 1000000) + 999) / 1000;
    localparam int BPSK_DIV      = `RFFE_CLK_HZ / `RFFE_BPSK_BPS;
    localparam int OQPSK_DIV     = `RFFE_CLK_HZ / `RFFE_OQPSK_BPS;
    localparam logic [5:0] AES_BASE = `RFFE_AES_DATA_BASE;
    if (LEAD_STEP_CYC < 1 || LEAD_STEP_CYC * 4 > 1023) begin : g_bad_lead_step
        $error("lead step out of range");
    end

    // ==========================================================
    // reset release
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // serial register port, mode 0, one command byte then one data byte
    logic       sclk_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] sh_q;
    logic [7:0] cmd_q;
    logic [7:0] rd_sh_q;
    logic       sclk_rise;
    logic       sclk_fall;
    logic [7:0] sh_next;
    logic       wr_stb;
    logic [5:0] wr_addr;
    logic [7:0] rd_data;

    assign sclk_rise = spi_sclk && !sclk_q && !spi_cs_n;
    assign sclk_fall = !spi_sclk && sclk_q && !spi_cs_n;
    assign sh_next   = {sh_q[6:0], spi_mosi};
    assign wr_addr   = cmd_q[5:0];
    // a write commits on the sixteenth rising edge
    assign wr_stb    = sclk_rise && bit_cnt_q == 4'hF && cmd_q[`RFFE_CMD_REG_BIT] && cmd_q[`RFFE_CMD_WRITE_BIT];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q    <= 1'b0;
            bit_cnt_q <= 4'h0;
            sh_q      <= 8'h00;
            cmd_q     <= 8'h00;
        end else begin
            sclk_q <= spi_sclk;
            if (spi_cs_n) begin
                bit_cnt_q <= 4'h0;
                cmd_q     <= 8'h00;
            end else if (sclk_rise) begin
                sh_q      <= sh_next;
                bit_cnt_q <= bit_cnt_q + 4'h1;
                if (bit_cnt_q == 4'h7) begin
                    cmd_q <= sh_next;
                end
            end
        end
    end

    // read byte is fetched at the first falling edge after the command byte
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_sh_q <= 8'h00;
        end else if (spi_cs_n) begin
            rd_sh_q <= 8'h00;
        end else if (sclk_fall) begin
            if (bit_cnt_q == 4'h8) begin
                rd_sh_q <= rd_data;
            end else begin
                rd_sh_q <= {rd_sh_q[6:0], 1'b0};
            end
        end
    end
    assign spi_miso = rd_sh_q[7];

    // ==========================================================
    // configuration registers
    logic       ext_fe_on_q;
    logic [1:0] lead_time_q;
    logic       rate_oqpsk_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_fe_on_q  <= `RFFE_EXT_FE_ON_RST;
            lead_time_q  <= `RFFE_LEAD_TIME_RST;
            rate_oqpsk_q <= `RFFE_RATE_RST;
        end else if (wr_stb) begin
            case (wr_addr)
                `RFFE_FRONTEND_CONTROL_ADDR: begin
                    ext_fe_on_q <= sh_next[`RFFE_EXT_FE_ON_BIT];
                end
                `RFFE_RF_LEAD_TIME_ADDR: begin
                    lead_time_q <= sh_next[`RFFE_LEAD_TIME_HI:`RFFE_LEAD_TIME_LO];
                end
                `RFFE_PHY_RATE_ADDR: begin
                    rate_oqpsk_q <= sh_next[`RFFE_RATE_OQPSK_BIT];
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // AES block buffer; accepted in any path state
    logic [7:0] aes_buf_q [16];
    logic       aes_done_q;
    logic       aes_start_q;
    logic       aes_ctrl_wr;
    logic       aes_buf_wr;
    assign aes_ctrl_wr = wr_stb && wr_addr == `RFFE_AES_CTRL_ADDR;
    assign aes_buf_wr  = wr_stb && wr_addr[5:4] == AES_BASE[5:4];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                aes_buf_q[i] <= 8'h00;
            end
        end else if (aes_rsp.done) begin
            // result overwrites a byte written in the same cycle
            for (int i = 0; i < 16; i++) begin
                aes_buf_q[i] <= aes_rsp.result[8*i +: 8];
            end
        end else if (aes_buf_wr) begin
            aes_buf_q[wr_addr[3:0]] <= sh_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aes_start_q <= 1'b0;
            aes_done_q  <= 1'b0;
        end else begin
            aes_start_q <= aes_ctrl_wr && sh_next[`RFFE_AES_START_BIT] && !aes_rsp.busy;
            if (aes_rsp.done) begin
                aes_done_q <= 1'b1;
            end else if (aes_ctrl_wr && sh_next[`RFFE_AES_DONE_BIT]) begin
                aes_done_q <= 1'b0;
            end
        end
    end

    always_comb begin
        aes_req.start = aes_start_q;
        for (int i = 0; i < 16; i++) begin
            aes_req.block[8*i +: 8] = aes_buf_q[i];
        end
    end

    // ==========================================================
    // path sequencer
    rffe_path_state_type state_q;
    logic [9:0]          lead_cnt_q;
    logic [9:0]          lead_cycles;
    logic                go_q;

    assign lead_cycles = 10'((int'(lead_time_q) + 1) * LEAD_STEP_CYC);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= RFFE_IDLE;
            lead_cnt_q <= 10'h000;
            go_q       <= 1'b0;
        end else begin
            go_q <= 1'b0;
            case (state_q)
                RFFE_IDLE: begin
                    // a transmit request outranks ongoing reception
                    if (tx_request) begin
                        state_q    <= RFFE_LEAD;
                        lead_cnt_q <= 10'h001;
                    end else if (rx_active) begin
                        state_q <= RFFE_RX;
                    end
                end
                RFFE_LEAD: begin
                    // amplifier is switched in ahead of the first symbol
                    if (lead_cnt_q >= lead_cycles) begin
                        state_q <= RFFE_TX;
                        go_q    <= 1'b1;
                    end else begin
                        lead_cnt_q <= lead_cnt_q + 10'h001;
                    end
                end
                RFFE_TX: begin
                    if (tx_done) begin
                        state_q <= RFFE_IDLE;
                    end
                end
                RFFE_RX: begin
                    if (tx_request) begin
                        state_q    <= RFFE_LEAD;
                        lead_cnt_q <= 10'h001;
                    end else if (!rx_active) begin
                        state_q <= RFFE_IDLE;
                    end
                end
                default: begin
                    state_q <= RFFE_IDLE;
                end
            endcase
        end
    end
    assign phy_tx_go = go_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            path_pins <= '0;
        end else begin
            path_pins.tx_path_select_pin <= ext_fe_on_q && (state_q == RFFE_LEAD || state_q == RFFE_TX);
            path_pins.rx_path_select_pin <= ext_fe_on_q && state_q == RFFE_RX;
        end
    end

    // ==========================================================
    // symbol-rate enable for the selected modulation
    logic [9:0] rate_cnt_q;
    logic       rate_tick_q;
    logic [9:0] rate_div;
    assign rate_div = rate_oqpsk_q ? 10'(OQPSK_DIV - 1) : 10'(BPSK_DIV - 1);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_cnt_q  <= 10'h000;
            rate_tick_q <= 1'b0;
        end else if (rate_cnt_q >= rate_div) begin
            rate_cnt_q  <= 10'h000;
            rate_tick_q <= 1'b1;
        end else begin
            rate_cnt_q  <= rate_cnt_q + 10'h001;
            rate_tick_q <= 1'b0;
        end
    end
    assign sym_rate_tick = rate_tick_q;

    // ==========================================================
    // read mux; unmapped addresses read zero
    always_comb begin
        rd_data = 8'h00;
        if (cmd_q[`RFFE_CMD_REG_BIT] && !cmd_q[`RFFE_CMD_WRITE_BIT]) begin
            if (cmd_q[5:4] == AES_BASE[5:4]) begin
                rd_data = aes_buf_q[cmd_q[3:0]];
            end else begin
                case (cmd_q[5:0])
                    `RFFE_FRONTEND_CONTROL_ADDR: rd_data[`RFFE_EXT_FE_ON_BIT] = ext_fe_on_q;
                    `RFFE_RF_LEAD_TIME_ADDR:     rd_data[`RFFE_LEAD_TIME_HI:`RFFE_LEAD_TIME_LO] = lead_time_q;
                    `RFFE_PHY_RATE_ADDR:         rd_data[`RFFE_RATE_OQPSK_BIT] = rate_oqpsk_q;
                    `RFFE_AES_CTRL_ADDR: begin
                        rd_data[`RFFE_AES_DONE_BIT] = aes_done_q;
                        rd_data[`RFFE_AES_BUSY_BIT] = aes_rsp.busy;
                    end
                    `RFFE_PATH_STATUS_ADDR: begin
                        rd_data[1] = path_pins.tx_path_select_pin;
                        rd_data[0] = path_pins.rx_path_select_pin;
                    end
                    default: rd_data = 8'h00;
                endcase
            end
        end
    end

endmodule

// ===== core/rffe_map.svh
`ifndef RFFE_MAP_SVH
`define RFFE_MAP_SVH

// ==========================================================
// register offsets (serial register space)
`define RFFE_FRONTEND_CONTROL_ADDR 6'h04
`define RFFE_RF_LEAD_TIME_ADDR     6'h16
`define RFFE_PHY_RATE_ADDR         6'h0C
`define RFFE_AES_DATA_BASE         6'h20
`define RFFE_AES_CTRL_ADDR         6'h3C
`define RFFE_PATH_STATUS_ADDR      6'h3E

// ==========================================================
// field positions
`define RFFE_EXT_FE_ON_BIT     7
`define RFFE_LEAD_TIME_HI      7
`define RFFE_LEAD_TIME_LO      6
`define RFFE_RATE_OQPSK_BIT    0
`define RFFE_AES_DONE_BIT      0
`define RFFE_AES_START_BIT     1
`define RFFE_AES_BUSY_BIT      2
`define RFFE_CMD_REG_BIT       7
`define RFFE_CMD_WRITE_BIT     6

// ==========================================================
// reset values
`define RFFE_EXT_FE_ON_RST     1'b0
`define RFFE_LEAD_TIME_RST     2'h0
`define RFFE_RATE_RST          1'b0

// ==========================================================
// timing
`define RFFE_CLK_HZ            25000000
`define RFFE_LEAD_STEP_NS      2000
`define RFFE_BPSK_BPS          40000
`define RFFE_OQPSK_BPS         250000

`endif

// ===== core/rffe_pkg.sv
package rffe_pkg;

    typedef enum {
        RFFE_IDLE,
        RFFE_LEAD,
        RFFE_TX,
        RFFE_RX
    } rffe_path_state_type;

    typedef struct packed {
        logic tx_path_select_pin;
        logic rx_path_select_pin;
    } rffe_path_pins_type;

    typedef struct packed {
        logic         start;
        logic [127:0] block;
    } rffe_aes_req_type;

    typedef struct packed {
        logic         busy;
        logic         done;
        logic [127:0] result;
    } rffe_aes_rsp_type;

endpackage

// ===== tb/rffe_checker.sv
`timescale 1ns/100ps
// ==========================================
// port-level checker, bound into the front end
module rffe_checker (
    input wire logic                         ref_clk,
    input wire logic                         nrst,
    input wire logic                         spi_cs_n,
    input wire logic                         tx_done,
    input wire logic                         rx_active,
    input wire logic                         phy_tx_go,
    input wire logic                         sym_rate_tick,
    input wire rffe_pkg::rffe_path_pins_type path_pins,
    input wire rffe_pkg::rffe_aes_req_type   aes_req,
    input wire rffe_pkg::rffe_aes_rsp_type   aes_rsp
);
    import rffe_pkg::*;
    logic [9:0] gap_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ten bits hold the slow period with room to spare
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gap_q <= 10'h000;
        end else begin
            gap_q <= sym_rate_tick ? 10'h000 : gap_q + 10'h001;
        end
    end
    a_paths_exclusive: assert property (
        !(path_pins.tx_path_select_pin && path_pins.rx_path_select_pin)) else $error("both path enables high");
    a_rx_has_cause: assert property (
        path_pins.rx_path_select_pin |-> $past(rx_active) || $past(rx_active, 2)) else $error("rx enable without rx");
    a_tx_drop: assert property (
        tx_done && path_pins.tx_path_select_pin |-> ##2 !path_pins.tx_path_select_pin) else $error("tx enable stuck");
    a_tx_holds: assert property (
        path_pins.tx_path_select_pin && spi_cs_n && !tx_done && !$past(tx_done) |=> path_pins.tx_path_select_pin)
        else $error("tx enable dropped early");
    a_go_pulse: assert property (
        phy_tx_go |=> !phy_tx_go) else $error("go longer than one cycle");
    a_tick_spacing: assert property (
        sym_rate_tick |-> gap_q >= 10'h063) else $error("symbol ticks too close");
    a_start_pulse: assert property (
        aes_req.start |=> !aes_req.start) else $error("cipher start longer than one cycle");
    a_start_idle: assert property (
        aes_req.start |-> !$past(aes_rsp.busy)) else $error("cipher start while busy");
endmodule

bind rffe_frontend rffe_checker chk (
    .ref_clk(ref_clk), .nrst(nrst), .spi_cs_n(spi_cs_n), .tx_done(tx_done), .rx_active(rx_active),
    .phy_tx_go(phy_tx_go), .sym_rate_tick(sym_rate_tick), .path_pins(path_pins), .aes_req(aes_req),
    .aes_rsp(aes_rsp)
);

// ===== tb/rffe_partner.sv
`timescale 1ns/100ps
// ==========================================
// behavioural cipher engine beside the front end
module rffe_partner #(
    parameter logic [127:0] KEY = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978
) (
    input wire logic                       ref_clk,
    input wire logic                       nrst,
    input wire rffe_pkg::rffe_aes_req_type aes_req,
    output     rffe_pkg::rffe_aes_rsp_type aes_rsp
);
    import rffe_pkg::*;
    logic [4:0] wait_q;
    // latency is drawn at random for each block, from 1 to 20 cycles
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 5'h00;
            aes_rsp <= '0;
        end else begin
            aes_rsp.done <= 1'b0;
            if (aes_req.start && wait_q == 5'h00) begin
                wait_q <= 5'($urandom_range(20, 1));
                aes_rsp.busy <= 1'b1;
                aes_rsp.result <= ~aes_rsp.result;
            end else if (wait_q == 5'h01) begin
                wait_q <= 5'h00;
                aes_rsp.busy <= 1'b0;
                aes_rsp.done <= 1'b1;
                aes_rsp.result <= aes_req.block ^ KEY;
            end else if (wait_q != 5'h00) begin
                wait_q <= wait_q - 5'h01;
            end
        end
    end
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
`include "rffe_map.svh"
// ==========================================
// top-level bench
module tb;
    import rffe_pkg::*;
    logic               ref_clk, nrst, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
    logic               tx_request, tx_done, rx_active, phy_tx_go, sym_rate_tick;
    rffe_path_pins_type path_pins;
    rffe_aes_req_type   aes_req;
    rffe_aes_rsp_type   aes_rsp;
    logic [7:0]         rd;
    logic [127:0]       blk;
    int                 failures, num_checks, cyc, k;
    // engine key is arbitrary; only the xor relation is checked
    localparam logic [127:0] CIPHER_KEY = 128'h5a3c_96e1_0f7b_2d48_c1e9_7a36_b05d_e284;

    rffe_frontend #(.LEAD_STEP_NS(200)) uut (
        .ref_clk(ref_clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .tx_request(tx_request), .tx_done(tx_done), .rx_active(rx_active),
        .phy_tx_go(phy_tx_go), .sym_rate_tick(sym_rate_tick), .path_pins(path_pins), .aes_req(aes_req),
        .aes_rsp(aes_rsp)
    );
    rffe_partner #(.KEY(CIPHER_KEY)) fe (.ref_clk(ref_clk), .nrst(nrst), .aes_req(aes_req), .aes_rsp(aes_rsp));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            complete_run();
        end
    end

    function automatic int lead_cycles(input int lt);
        return (lt + 1) * 200 * (`RFFE_CLK_HZ / 1000000) / 1000;
    endfunction
    function automatic int tick_cycles(input logic oqpsk);
        return `RFFE_CLK_HZ / (oqpsk ? `RFFE_OQPSK_BPS : `RFFE_BPSK_BPS);
    endfunction
    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // sclk levels last two cycles each, slow enough for the edge detector
    task automatic spi(input logic [7:0] cmd, input logic [7:0] wd);
        logic [15:0] sh;
        sh = {cmd, wd};
        spi_cs_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            spi_sclk = 1'b0;
            spi_mosi = sh[15 - i];
            tick(2);
            if (i > 7) rd[15 - i] = spi_miso;
            spi_sclk = 1'b1;
            tick(2);
        end
        spi_sclk = 1'b0;
        spi_mosi = ~spi_mosi;
        tick(2);
        spi_cs_n = 1'b1;
        tick(2);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        spi({2'b11, a}, d);
    endtask
    task automatic rdchk(input string n, input logic [5:0] a, input logic [7:0] e);
        spi({2'b10, a}, 8'h00);
        check(n, rd, e);
    endtask
    task automatic gap;
        tick(1);
        k = 1;
        while (sym_rate_tick !== 1'b1 && k < 700) begin
            tick(1);
            k++;
        end
    endtask
    task automatic send(input int lt, input logic on);
        tx_request = 1'b1;
        tick(1);
        tx_request = 1'b0;
        k = 0;
        while (phy_tx_go !== 1'b1 && k < 400) begin
            if (k == 2) check("tx enable", path_pins, {on, 1'b0});
            tick(1);
            k++;
        end
        check("lead time", k, lead_cycles(lt));
        tick(1 + $urandom_range(9));
        tx_done = 1'b1;
        tick(1);
        tx_done = 1'b0;
        tick(2);
        check("tx release", path_pins.tx_path_select_pin, 1'b0);
    endtask

    initial begin
        nrst = 1'b0;
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        tx_request = 1'b0;
        tx_done = 1'b0;
        rx_active = 1'b0;
        k = $urandom(32'h1c5a_8522);
        tick(6);
        nrst = 1'b1;
        tick(4);
        check("idle enables", path_pins, 2'b00);
        rdchk("front-end reset", `RFFE_FRONTEND_CONTROL_ADDR, 8'h00);
        rdchk("lead reset", `RFFE_RF_LEAD_TIME_ADDR, 8'h00);
        rdchk("unmapped", 6'h3F, 8'h00);
        for (int on = 0; on < 2; on++) begin
            wr(`RFFE_FRONTEND_CONTROL_ADDR, {on[0], 7'h00});
            for (int lt = 0; lt < 4; lt++) begin
                wr(`RFFE_RF_LEAD_TIME_ADDR, {lt[1:0], 6'h00});
                rdchk("lead field", `RFFE_RF_LEAD_TIME_ADDR, {lt[1:0], 6'h00});
                send(lt, on[0]);
            end
        end
        rx_active = 1'b1;
        tick(2 + $urandom_range(5));
        check("rx enables", path_pins, 2'b01);
        rdchk("path status", `RFFE_PATH_STATUS_ADDR, 8'h01);
        send(3, 1'b1);
        tick(3);
        check("rx resumes", path_pins, 2'b01);
        wr(`RFFE_FRONTEND_CONTROL_ADDR, 8'h00);
        check("sleep enables", path_pins, 2'b00);
        rx_active = 1'b0;
        for (int r = 0; r < 2; r++) begin
            wr(`RFFE_PHY_RATE_ADDR, {7'h00, r[0]});
            gap();
            gap();
            check("symbol period", k, tick_cycles(r[0]));
        end
        for (int i = 0; i < 16; i++) begin
            blk[8*i +: 8] = 8'($urandom);
            wr(`RFFE_AES_DATA_BASE + 6'(i), blk[8*i +: 8]);
        end
        check("cipher block", aes_req.block, blk);
        wr(`RFFE_AES_CTRL_ADDR, 8'h02);
        rdchk("cipher done", `RFFE_AES_CTRL_ADDR, 8'h01);
        check("cipher result", aes_req.block, blk ^ CIPHER_KEY);
        rdchk("cipher byte", `RFFE_AES_DATA_BASE + 6'h05, blk[47:40] ^ CIPHER_KEY[47:40]);
        wr(`RFFE_AES_CTRL_ADDR, 8'h01);
        rdchk("done cleared", `RFFE_AES_CTRL_ADDR, 8'h00);
        complete_run();
    end
endmodule
